//--- design/rha_params.svh
`ifndef RHA_PARAMS_SVH
`define RHA_PARAMS_SVH
// Config register field positions
`define RHA_BIT_IRQ 7
`define RHA_BIT_STEP 6
`define RHA_BIT_FBW 5
`define RHA_BIT_LRD 4
`define RHA_BIT_LWR 3
`define RHA_BIT_RUN 2
// Memory select encodings
`define RHA_MS_DATA 2'h0
`define RHA_MS_INSTR 2'h1
`define RHA_MS_PCLO 2'h2
`define RHA_MS_PCHI 2'h3
// Config reset value: instruction memory selected, core stopped
`define RHA_CFG_RESET 8'h01
// Access phase least length in T-states
`define RHA_ACC_MIN 2
// Instruction write yield least length in T-states
`define RHA_IWR_MIN 3
`endif

//--- design/rha_pkg.sv
package rha_pkg;
    // Arbiter phases
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARB,
        ST_SETUP,
        ST_ACCESS,
        ST_TERM,
        ST_HOLD
    } rha_state_t;
    // Latched access descriptor
    typedef struct packed {
        logic is_write;
        logic is_cfg;
        logic [1:0] msel;
    } rha_cmd_t;
endpackage

//--- design/rha_byte_ptr.sv
`timescale 1ns/1ns
// Instruction byte pointer: low byte first, toggles per instruction access
module rha_byte_ptr
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic toggle_i,
    input wire logic force_low_i,
    output logic high_o
);
    logic high_reg;
    logic high_next;

    // Forced low wins so a fresh word boundary is always honoured
    assign high_next = force_low_i ? 1'b0 : (toggle_i ? ~high_reg : high_reg);

    // Pointer state
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            high_reg <= 1'b0;
        end
        else
        begin
            high_reg <= high_next;
        end
    end

    assign high_o = high_reg;
endmodule

//--- design/rha_arbiter.sv
`timescale 1ns/1ns
`include "rha_params.svh"
// Overview of operation
// - Config byte: irq, step, fbw, lrd, lwr, run, msel
// - Select low plus either strobe starts access
// - Acknowledge drops low soon after access start
// - Yield bus once core leaves data memory
// - Arbitration at least one T-state, lengthened
// - Command select sampled once, held whole access
// - Internal strobe falls one T-state after yield
// - Access phase two T-states plus waits
// - Ack rise ends access; yield falls later
// - Config byte drives bus by default
// - Config write captured at ack rise
// - Data access floats bus, memory strobes
// - Select 11 PC high, 10 PC low
// - PC read valid after yield; writes float
// - Instruction memory selected at power-up
// - Low then high byte; PC increments after high
// - Byte pointer resets, toggles, forced low
// - Instruction read byte drives bus, waits
// - Instruction write yields three T-states
// - Fast buffered write bit chooses fast ending
// - Latched read and latched write mode bits
// - Run bit starts and stops the core
// - Step bit runs one instruction, reads zero
module rha_arbiter
    import rha_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    input wire logic REMOTE_SELECT_N_I,
    input wire logic HOST_READ_N_I,
    input wire logic HOST_WRITE_N_I,
    input wire logic CMD_SELECT_I,
    input wire logic WAIT_N_I,
    input wire logic REMOTE_LOCKOUT_I,
    input wire logic LOCAL_DATA_MEMORY_BUSY_I,
    input wire logic [1:0] DATA_WAIT_STATES_I,
    input wire logic [1:0] INSTR_WAIT_STATES_I,
    input wire logic [7:0] AD_I,
    output logic [7:0] AD_O,
    output logic AD_OE_O,
    output logic TRANSFER_ACK_N_O,
    output logic BUS_YIELD_O,
    output logic MEM_READ_N_O,
    output logic MEM_WRITE_N_O,
    output logic INSTR_WRITE_STROBE_N_O,
    output logic [15:0] INSTR_WORD_O,
    input wire logic [15:0] INSTR_I,
    output logic [15:0] PC_O,
    output logic RUN_O,
    output logic STEP_PULSE_O,
    input wire logic STEP_DONE_I,
    input wire logic IRQ_STATUS_I,
    output logic FAST_BUFFERED_WRITE_O,
    output logic LATCHED_READ_O,
    output logic LATCHED_WRITE_O
);
    rha_state_t state_reg; // Arbiter phase
    rha_state_t state_next;
    rha_cmd_t cmd_reg; // Access descriptor caught at start
    logic [7:0] cfg_reg; // Config byte, step bit kept apart
    logic step_reg; // Single-step request pending
    logic [15:0] pc_reg; // Program counter
    logic [7:0] low_hold_reg; // Low instruction byte holding
    logic [2:0] cnt_reg; // Phase T-state counter
    logic arb_first_reg; // High during the first arbitration cycle only
    logic [2:0] cnt_next;
    logic [7:0] rd_reg; // Read data held for the host
    logic byte_high; // Byte pointer state
    logic ptr_toggle;
    logic ptr_force_low;

    // Request decode, no ordering between select and strobe
    wire req = ~REMOTE_SELECT_N_I & (~HOST_READ_N_I | ~HOST_WRITE_N_I);
    wire is_instr = ~cmd_reg.is_cfg & (cmd_reg.msel == `RHA_MS_INSTR);
    wire is_data = ~cmd_reg.is_cfg & (cmd_reg.msel == `RHA_MS_DATA);
    wire is_pc = ~cmd_reg.is_cfg & cmd_reg.msel[1];
    wire bus_free = ~LOCAL_DATA_MEMORY_BUSY_I & ~REMOTE_LOCKOUT_I;

    // Access length: base plus programmed waits by target
    function automatic logic [2:0] acc_len(input rha_cmd_t c, input logic [1:0] dws,
                                           input logic [1:0] iws);
        logic [2:0] len;
        len = 3'(`RHA_ACC_MIN);
        if (!c.is_cfg && c.msel == `RHA_MS_DATA)
            len = len + {1'b0, dws};
        else if (!c.is_cfg && c.msel == `RHA_MS_INSTR)
            len = len + {1'b0, iws} + 3'(c.is_write); // Write yields a T-state longer
        acc_len = len;
    endfunction

    wire [2:0] need = acc_len(cmd_reg, DATA_WAIT_STATES_I, INSTR_WAIT_STATES_I);
    wire acc_done = (cnt_reg >= need - 3'h1) & WAIT_N_I;
    // Termination end depends on interface mode
    wire slow_end = cmd_reg.is_write ? (~cfg_reg[`RHA_BIT_LWR] & ~cfg_reg[`RHA_BIT_FBW])
                                     : ~cfg_reg[`RHA_BIT_LRD];
    wire strobe_gone = cmd_reg.is_write ? HOST_WRITE_N_I : HOST_READ_N_I;

    // Phase sequencing
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (req)
                    state_next = ST_ARB;
            end
            ST_ARB:
            begin
                if (bus_free || cmd_reg.is_cfg)
                    state_next = ST_SETUP;
            end
            ST_SETUP:
            begin
                state_next = ST_ACCESS;
                cnt_next = 3'h0;
            end
            ST_ACCESS:
            begin
                if (acc_done)
                    state_next = ST_TERM;
                else
                    cnt_next = cnt_reg + 3'h1;
            end
            ST_TERM:
            begin
                if (!slow_end || strobe_gone)
                    state_next = ST_HOLD;
            end
            ST_HOLD:
            begin
                if (!req)
                    state_next = ST_IDLE; // Wait for host to finish strobe
            end
            default:
            begin
                state_next = ST_IDLE; // Unused codes fall back to idle
            end
        endcase
    end

    // State and counter
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= 3'h0;
            arb_first_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            arb_first_reg <= (state_reg == ST_IDLE) & req;
        end
    end

    // Command select sampled on the first falling edge after start, never again
    always_ff @(negedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            cmd_reg <= '0;
        end
        else if (arb_first_reg)
        begin
            cmd_reg <= '{~HOST_WRITE_N_I, CMD_SELECT_I, cfg_reg[1:0]};
        end
    end

    wire ack_rise = (state_reg == ST_ACCESS) & acc_done;
    wire wr_commit = ack_rise & cmd_reg.is_write;
    wire instr_acc = ack_rise & is_instr;
    wire cfg_wr = wr_commit & cmd_reg.is_cfg;
    // Core is assumed stopped for PC and instruction accesses; host keeps this
    wire pc_inc = instr_acc & byte_high;

    // Config byte, captured on ack rise
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            cfg_reg <= `RHA_CFG_RESET;
            step_reg <= 1'b0;
        end
        else if (cfg_wr)
        begin
            cfg_reg <= {1'b0, 1'b0, AD_I[5:0]};
            step_reg <= AD_I[`RHA_BIT_STEP] | (step_reg & ~STEP_DONE_I);
        end
        else if (STEP_DONE_I)
            step_reg <= 1'b0;
    end

    // Program counter and holding register
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            pc_reg <= 16'h0000;
            low_hold_reg <= 8'h00;
        end
        else
        begin
            if (wr_commit && is_pc && cmd_reg.msel[0])
                pc_reg[15:8] <= AD_I;
            else if (wr_commit && is_pc)
                pc_reg[7:0] <= AD_I;
            else if (pc_inc)
                pc_reg <= pc_reg + 16'h0001;
            if (instr_acc && !byte_high && cmd_reg.is_write)
                low_hold_reg <= AD_I;
        end
    end

    assign ptr_toggle = instr_acc;
    assign ptr_force_low = cfg_wr & (AD_I[1:0] == `RHA_MS_INSTR);

    rha_byte_ptr u_ptr
    (
        .clk_i(SYS_CLK_I),
        .nrst_i(NRST_I),
        .toggle_i(ptr_toggle),
        .force_low_i(ptr_force_low),
        .high_o(byte_high)
    );

    // Readback byte by target
    wire [7:0] cfg_view = {IRQ_STATUS_I, 1'b0, cfg_reg[5:0]};
    wire [7:0] rd_sel = is_pc ? (cmd_reg.msel[0] ? pc_reg[15:8] : pc_reg[7:0])
                      : is_instr ? (byte_high ? INSTR_I[15:8] : INSTR_I[7:0])
                      : cfg_view;

    // Bus data register: config by default, target byte loaded during a read's access phase
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            rd_reg <= 8'h00;
        else if (state_reg == ST_ACCESS && !cmd_reg.is_write)
            rd_reg <= rd_sel;
        else
            rd_reg <= cfg_view;
    end

    wire yield = (state_reg == ST_SETUP) | (state_reg == ST_ACCESS) | (state_reg == ST_TERM);
    wire in_acc = state_reg == ST_ACCESS;

    assign BUS_YIELD_O = yield;
    assign TRANSFER_ACK_N_O = ~((state_reg == ST_ARB) | (state_reg == ST_SETUP) | in_acc);
    // Bus floats for writes and data accesses while yielded
    assign AD_OE_O = ~(yield & (cmd_reg.is_write | is_data));
    assign AD_O = rd_reg;
    assign MEM_READ_N_O = ~(in_acc & ~cmd_reg.is_write & is_data);
    assign MEM_WRITE_N_O = ~(in_acc & cmd_reg.is_write & is_data);
    assign INSTR_WRITE_STROBE_N_O = ~(in_acc & cmd_reg.is_write & is_instr & byte_high);
    assign INSTR_WORD_O = {AD_I, low_hold_reg};
    assign PC_O = pc_reg;
    assign RUN_O = cfg_reg[`RHA_BIT_RUN];
    assign STEP_PULSE_O = step_reg;
    assign FAST_BUFFERED_WRITE_O = cfg_reg[`RHA_BIT_FBW];
    assign LATCHED_READ_O = cfg_reg[`RHA_BIT_LRD];
    assign LATCHED_WRITE_O = cfg_reg[`RHA_BIT_LWR];

    // Arbitration holds at least one T-state before yield
    property p_arb_min;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        $rose(BUS_YIELD_O) |-> $past(state_reg) == ST_ARB;
    endproperty
    a_arb_min: assert property (p_arb_min) else $error("yield without arbitration");

    // No yield for a non-config access while core holds data memory
    property p_no_yield_busy;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        (state_reg == ST_ARB && LOCAL_DATA_MEMORY_BUSY_I && !cmd_reg.is_cfg) |=> !BUS_YIELD_O;
    endproperty
    a_no_yield_busy: assert property (p_no_yield_busy) else $error("yield during local");

    // Strobe falls one T-state after yield rises
    property p_strobe_delay;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        $rose(BUS_YIELD_O) && is_data |=> !MEM_READ_N_O || !MEM_WRITE_N_O;
    endproperty
    a_strobe_delay: assert property (p_strobe_delay) else $error("strobe late");

    // Access phase lasts at least two T-states
    property p_acc_min;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        $rose(state_reg == ST_ACCESS) |-> (state_reg == ST_ACCESS)[*2];
    endproperty
    a_acc_min: assert property (p_acc_min) else $error("access too short");

    // Yield falls one T-state after ack rises, at least
    property p_term;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        $rose(TRANSFER_ACK_N_O) |-> BUS_YIELD_O;
    endproperty
    a_term: assert property (p_term) else $error("yield dropped with ack");

    // Ack low within a cycle of a request
    property p_ack;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        (state_reg == ST_IDLE && req) |=> !TRANSFER_ACK_N_O;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not asserted");

    // PC advances only after a high byte access
    property p_pc_inc;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        pc_inc |=> pc_reg == $past(pc_reg) + 16'h0001;
    endproperty
    a_pc_inc: assert property (p_pc_inc) else $error("pc not incremented");

    // Step bit always reads zero
    property p_step_zero;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        AD_OE_O && !BUS_YIELD_O |-> !AD_O[`RHA_BIT_STEP];
    endproperty
    a_step_zero: assert property (p_step_zero) else $error("step bit visible");

    // Selecting instruction memory forces low byte
    property p_ptr_low;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        ptr_force_low |=> !byte_high;
    endproperty
    a_ptr_low: assert property (p_ptr_low) else $error("pointer not low");

    // Command descriptor frozen once its falling edge has passed
    property p_cmd_once;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        (state_reg != ST_IDLE) && !arb_first_reg |=> $stable(cmd_reg);
    endproperty
    a_cmd_once: assert property (p_cmd_once) else $error("command resampled");

    // Instruction write keeps the bus yielded three T-states at least
    property p_iwr_yield;
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        $rose(BUS_YIELD_O) && is_instr && cmd_reg.is_write |-> BUS_YIELD_O[*3];
    endproperty
    a_iwr_yield: assert property (p_iwr_yield) else $error("instruction yield short");
endmodule

//--- tb/rha_host_model.sv
`timescale 1ns/1ns
// Remote host: moves its lines on falling edges only
module rha_host_model
(
    input wire logic clk_i,
    input wire logic ack_n_i,
    input wire logic [7:0] ad_i,
    output logic sel_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic cmd_o,
    output logic [7:0] ad_o
);
    // Idle host, strobes released
    initial
    begin
        sel_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        cmd_o = 1'b0;
        ad_o = 8'h5a;
    end

    // One cycle; flip turns the command line round mid-access on purpose
    task automatic access(input bit wr, input bit c, input bit flip, input logic [7:0] d,
                          output logic [7:0] q, output bit ok);
        bit seen;
        seen = 1'b0;
        ok = 1'b0;
        q = 8'h00;
        @(negedge clk_i);
        cmd_o = c;
        ad_o = d;
        sel_n_o = 1'b0;
        rd_n_o = wr;
        wr_n_o = !wr;
        // Bounded wait on settled outputs: ack low, then ack high
        for (int n = 0; n < 80 && !ok; n++)
        begin
            @(negedge clk_i);
            if (!ack_n_i)
                seen = 1'b1;
            else if (seen)
            begin
                q = ad_i;
                ok = 1'b1;
            end
            // Late change lands after the device has sampled this edge
            if (seen && flip)
                cmd_o <= !c;
        end
        // Release only once the answer has been taken
        sel_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        // Released bus must not look like held data
        ad_o = ~ad_o;
        repeat (3) @(negedge clk_i);
    endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ns
`include "rha_params.svh"
module tb;
    logic clk, nrst, sel_n, rd_n, wr_n, cmd, wait_n, lock, busy, step_done, irq;
    logic [1:0] dws, iws;
    logic [7:0] ad_dev, host_ad, ad_bus, q;
    logic ack_n, yld, mrd_n, mwr_n, iwr_n, run, stp, fast_buffered_write, lrd, lwr, ad_oe, y_q, a_q;
    logic [15:0] iword, instr, pc, p, iw_cap;
    logic [31:0] seed;
    int num_errors, n_tests, cyc, t_yr, t_ar, t_yf, t1, n_st, n_drv, n_iw;

    // Device drives the shared bus when enabled, else the host side
    assign ad_bus = ad_oe ? ad_dev : host_ad;

    rha_arbiter uut (
        .SYS_CLK_I(clk), .NRST_I(nrst), .REMOTE_SELECT_N_I(sel_n), .HOST_READ_N_I(rd_n),
        .HOST_WRITE_N_I(wr_n), .CMD_SELECT_I(cmd), .WAIT_N_I(wait_n), .REMOTE_LOCKOUT_I(lock),
        .LOCAL_DATA_MEMORY_BUSY_I(busy), .DATA_WAIT_STATES_I(dws), .INSTR_WAIT_STATES_I(iws),
        .AD_I(ad_bus), .AD_O(ad_dev), .AD_OE_O(ad_oe), .TRANSFER_ACK_N_O(ack_n),
        .BUS_YIELD_O(yld), .MEM_READ_N_O(mrd_n), .MEM_WRITE_N_O(mwr_n),
        .INSTR_WRITE_STROBE_N_O(iwr_n), .INSTR_WORD_O(iword), .INSTR_I(instr), .PC_O(pc),
        .RUN_O(run), .STEP_PULSE_O(stp), .STEP_DONE_I(step_done), .IRQ_STATUS_I(irq),
        .FAST_BUFFERED_WRITE_O(fast_buffered_write), .LATCHED_READ_O(lrd), .LATCHED_WRITE_O(lwr)
    );

    rha_host_model host (
        .clk_i(clk), .ack_n_i(ack_n), .ad_i(ad_bus), .sel_n_o(sel_n), .rd_n_o(rd_n),
        .wr_n_o(wr_n), .cmd_o(cmd), .ad_o(host_ad)
    );

    // 100 MHz core clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Handshake edge stamps, taken half a cycle after the launching edge
    always @(negedge clk)
    begin
        cyc = cyc + 1;
        if (yld && !y_q) t_yr = cyc;
        if (!yld && y_q) t_yf = cyc;
        if (ack_n && !a_q) t_ar = cyc;
        // Write strobe cycles weigh 16 so one count tells read from write
        if (!mrd_n) n_st++;
        if (!mwr_n) n_st += 16;
        if (yld && ad_oe) n_drv++;
        if (!iwr_n)
        begin
            n_iw++;
            iw_cap = iword;
        end
        y_q = yld;
        a_q = ack_n;
    end

    // Fixed-seed pseudo random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Config readback: status from pin, step always low
    function automatic logic [7:0] exp_cfg(input logic [7:0] v, input logic i);
        return {i, 1'b0, v[5:0]};
    endfunction

    task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Count or cycle span within limits
    task automatic chk_c(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One host access; a stalled handshake ends the run
    task automatic acc(input bit wr, input bit c, input bit flip, input logic [7:0] d);
        bit ok;
        n_st = 0;
        n_drv = 0;
        n_iw = 0;
        host.access(wr, c, flip, d, q, ok);
        if (!ok)
        begin
            num_errors++;
            report_and_stop();
        end
    endtask

    // Yield rise to ack rise, then ack rise to yield fall
    task automatic tim(input int alen);
        chk_c(t_ar - t_yr, alen + 1, alen + 1);
        chk_c(t_yf - t_ar, 1, 3);
    endtask

    task automatic wcfg(input logic [7:0] v);
        acc(1'b1, 1'b1, 1'b0, v);
        tim(`RHA_ACC_MIN);
    endtask

    initial
    begin
        nrst = 1'b0;
        wait_n = 1'b1;
        {lock, busy, step_done, irq, dws, iws} = 0;
        instr = 16'h0000;
        seed = 32'h45b616e2;
        {num_errors, n_tests, cyc, t_yr, t_ar, t_yf} = 0;
        {y_q, a_q} = 2'b01;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        // Out of reset: config byte reaches the bus at the first edge
        @(negedge clk);
        chk_v({ad_oe, ad_dev}, {1'b1, `RHA_CFG_RESET});
        acc(1'b0, 1'b1, 1'b0, 8'h00);
        chk_v(q, `RHA_CFG_RESET);
        // Random mode bytes, step handshake, readback
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            irq = seed[8];
            wcfg(seed[7:0]);
            chk_v({fast_buffered_write, lrd, lwr, run}, seed[5:2]);
            chk_v(stp, seed[6]);
            step_done = 1'b1;
            @(negedge clk);
            step_done = 1'b0;
            chk_v(stp, 1'b0);
            acc(1'b0, 1'b1, 1'b0, 8'h00);
            chk_v(q, exp_cfg(seed[7:0], irq));
        end
        // PC bytes; command flips mid-read and must be ignored
        seed = lfsr(seed);
        wcfg(8'h23);
        acc(1'b1, 1'b0, 1'b0, seed[15:8]);
        chk_c(n_drv, 0, 0);
        tim(2);
        wcfg(8'h22);
        acc(1'b1, 1'b0, 1'b0, seed[7:0]);
        chk_v(pc, seed[15:0]);
        acc(1'b0, 1'b0, 1'b1, 8'h00);
        chk_v(q, seed[7:0]);
        wcfg(8'h23);
        acc(1'b0, 1'b0, 1'b0, 8'h00);
        chk_v(q, seed[15:8]);
        // Download and read back with every instruction wait count
        for (int w = 0; w < 4; w++)
        begin
            iws = w[1:0];
            seed = lfsr(seed);
            wcfg(8'h21);
            acc(1'b1, 1'b0, 1'b0, seed[23:16]);
            wcfg(8'h21);
            p = pc;
            acc(1'b1, 1'b0, 1'b0, seed[7:0]);
            tim(w + 3);
            chk_c(n_iw, 0, 0);
            acc(1'b0, 1'b1, 1'b0, 8'h00);
            acc(1'b1, 1'b0, 1'b0, seed[15:8]);
            chk_c(n_iw, 1, 99);
            chk_v(iw_cap, seed[15:0]);
            chk_v(pc, p + 16'h0001);
            instr = seed[31:16];
            acc(1'b0, 1'b0, 1'b0, 8'h00);
            chk_v(q, instr[7:0]);
            tim(w + 2);
            acc(1'b0, 1'b0, 1'b0, 8'h00);
            chk_v(q, instr[15:8]);
            chk_v(pc, p + 16'h0002);
        end
        // Data memory: floated bus, strobe of the right kind spans waits
        wcfg(8'h20);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            dws = seed[1:0];
            acc(seed[2], 1'b0, 1'b0, seed[15:8]);
            tim(2 + dws);
            t1 = (seed[2] ? 16 : 1) * (2 + dws);
            chk_c(n_st, t1, t1);
            chk_c(n_drv, 0, 0);
        end
        // Local busy, then lockout, hold back the yield
        for (int i = 0; i < 2; i++)
        begin
            busy = (i == 0);
            lock = (i == 1);
            fork
                acc(1'b0, 1'b0, 1'b0, 8'h00);
                begin
                    repeat (8) @(negedge clk);
                    {busy, lock} = 2'b00;
                    t1 = cyc;
                end
            join
            chk_c(t_yr - t1, 0, 3);
        end
        // Config access is not held off by lockout
        lock = 1'b1;
        acc(1'b0, 1'b1, 1'b0, 8'h00);
        tim(2);
        lock = 1'b0;
        // Wait input stretches the access phase
        wait_n = 1'b0;
        fork
            acc(1'b1, 1'b1, 1'b0, 8'h21);
            begin
                repeat (12) @(negedge clk);
                wait_n = 1'b1;
            end
        join
        chk_c(t_ar - t_yr, 5, 40);
        report_and_stop();
    end
endmodule
